// file: logic/serdes_pkg.sv
// Shared constants of the word serializer, deserializer and comma aligner
package serdes_pkg;
  localparam int        WORD_BITS       = 10;
  localparam int        FIFO_DEPTH      = 8;
  // Comma word with the first arrived bit in bit 0
  localparam logic [9:0] COMMA_WORD     = 10'h17C;
  localparam logic [9:0] IDLE_WORD      = 10'h000;
  localparam logic [3:0] BIT_LAST       = 4'h9;
  localparam logic [3:0] REF_PHASE_LAST = 4'h9;
  localparam logic [4:0] BYTE_LAST      = 5'h13;
  localparam logic [4:0] BYTE_HALF_LAST = 5'h09;
  localparam logic [4:0] BYTE_HALF      = 5'h0A;
  localparam logic [4:0] PULSE_END      = 5'h05;
  // Pin synchroniser lanes
  localparam int        LANE_SERIAL     = 0;
  localparam int        LANE_ALIGN      = 1;
  localparam int        LANE_LOCK_N     = 2;
  localparam int        LANE_LOOP       = 3;
  localparam logic [3:0] SYNC_RESET     = 4'h4;
endpackage : serdes_pkg

// file: logic/tx_word_fifo.sv
// Parameterised word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module tx_word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("tx_word_fifo: DEPTH must be a power of two of at least 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("tx_word_fifo: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wrPtr;
    logic [PTR_W-1:0]            rdPtr;
    logic [CNT_W-1:0]            count;
    logic                        full;
    logic                        empty;
  } fifo_state_type;

  localparam fifo_state_type FIFO_RESET = '{
    mem: '0, wrPtr: '0, rdPtr: '0, count: '0, full: 1'b0, empty: 1'b1};

  fifo_state_type state;
  fifo_state_type next_state;
  logic           push;
  logic           pop;

  always_comb begin
    next_state = state;
    push = inValid && !state.full;
    pop  = outReady && !state.empty;
    if (push) begin
      next_state.mem[state.wrPtr] = inData;
      next_state.wrPtr = state.wrPtr + 1'b1;
    end
    if (pop) begin
      next_state.rdPtr = state.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
    // Flags registered so the ready seen outside is a flop
    next_state.full  = next_state.count == CNT_W'(DEPTH);
    next_state.empty = next_state.count == '0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= FIFO_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign inReady  = !state.full;
  assign outValid = !state.empty;
  assign outData  = state.mem[state.rdPtr];
endmodule : tx_word_fifo

// file: logic/gigabit_serdes_comma_align.sv
// Bit-rate model of the word serializer, deserializer and comma aligner
`timescale 1ns/1ps
// Behaviour
// - Capture transmit word on reference edge
// - Bit rate is ten times reference
// - Transmit bit 0 first, bit 9 last
// - Last bit leaves about nine bit-times after load
// - Retime received bits on recovered bit clock
// - Two byte clocks, word rate halved, antiphase
// - Byte 0 valid on second clock rise
// - Received bit 0 arrived first
// - Comma pulse lasts half reference period
// - Comma pulse coincides with byte 0
// - Comma pulse only while alignment enabled
// - Search comma and realign word boundary
// - Alignment disabled: no realign, unframed words
// - Lock-to-reference phases receiver to reference
// - Receiver locks to data without preset
// - Loopback routes serial internally, output static
// - Byte clocks only stretched during realign
// - First clock bytes 1,3; second 0,2
module gigabit_serdes_comma_align #(
  parameter int FIFO_WORDS = serdes_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [9:0] txWordIn,
  input  wire logic       txWordValid,
  output logic            txWordReady,
  output logic            serialOut,
  input  wire logic       serialIn,
  input  wire logic       alignEnable,
  input  wire logic       refLockN,
  input  wire logic       loopbackEnable,
  output logic      [9:0] rxWordOut,
  output logic            rxByteClockA,
  output logic            rxByteClockB,
  output logic            commaDetect
);
  if (FIFO_WORDS < 2) begin : g_bad_fifo
    $error("gigabit_serdes_comma_align: FIFO_WORDS must be at least 2");
  end

  typedef struct packed {
    logic [3:0] syncFirst;
    logic [3:0] syncSecond;
    logic [3:0] refPhase;
    logic [9:0] txShift;
    logic       serialOut;
    logic [9:0] rxHist;
    logic [3:0] bitCount;
    logic [4:0] byteCount;
    logic [3:0] stall;
    logic [9:0] holdWord;
    logic       pendingComma;
    logic [9:0] rxWordOut;
    logic       byteClockA;
    logic       byteClockB;
    logic       commaDetect;
  } serdes_state_type;

  localparam serdes_state_type SERDES_RESET = '{
    syncFirst: serdes_pkg::SYNC_RESET, syncSecond: serdes_pkg::SYNC_RESET,
    refPhase: 4'h0, txShift: serdes_pkg::IDLE_WORD, serialOut: 1'b0,
    rxHist: 10'h000, bitCount: 4'h0, byteCount: 5'h00, stall: 4'h0,
    holdWord: 10'h000, pendingComma: 1'b0, rxWordOut: 10'h000,
    byteClockA: 1'b0, byteClockB: 1'b1, commaDetect: 1'b0};

  serdes_state_type state;
  serdes_state_type next_state;
  logic             refTick;
  logic             fifoPop;
  logic             fifoOutValid;
  logic       [9:0] fifoOutData;
  logic             fifoInReady;
  logic             rxBit;
  logic       [9:0] newHist;
  logic             wordDone;
  logic             commaSeen;
  logic             advance;
  logic       [3:0] slip;
  logic             serialLine;
  logic             alignLine;
  logic             lockLineN;
  logic             loopLine;

  // Cycles to hold the byte counter so the comma lands on byte 0
  function automatic logic [3:0] slipFor(input logic [4:0] c);
    logic [4:0] s;
    s = 5'h00;
    if (c < serdes_pkg::BYTE_HALF_LAST) begin
      s = c + 5'h01;
    end else if (c < serdes_pkg::BYTE_LAST) begin
      s = c - serdes_pkg::BYTE_HALF_LAST;
    end
    return s[3:0];
  endfunction : slipFor

  // Byte counter values at which a byte clock is about to rise
  function automatic logic isRiseNext(input logic [4:0] c);
    return c == serdes_pkg::BYTE_LAST || c == serdes_pkg::BYTE_HALF_LAST;
  endfunction : isRiseNext

  // words accepted only on the reference tick
  tx_word_fifo #(
    .WIDTH (serdes_pkg::WORD_BITS),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .inData   (txWordIn),
    .inValid  (txWordValid && refTick),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  assign serialLine = state.syncSecond[serdes_pkg::LANE_SERIAL];
  assign alignLine  = state.syncSecond[serdes_pkg::LANE_ALIGN];
  assign lockLineN  = state.syncSecond[serdes_pkg::LANE_LOCK_N];
  assign loopLine   = state.syncSecond[serdes_pkg::LANE_LOOP];

  always_comb begin
    next_state = state;
    next_state.syncFirst  = {loopbackEnable, refLockN, alignEnable, serialIn};
    next_state.syncSecond = state.syncFirst;

    // reference tick every ten bit times
    refTick = state.refPhase == serdes_pkg::REF_PHASE_LAST;
    next_state.refPhase = refTick ? 4'h0 : state.refPhase + 4'h1;

    // bit 9 leaves nine bit times after load
    // load at word boundary, then shift out low bit first
    fifoPop = 1'b0;
    if (refTick) begin
      // Transmitter idles while the PLL is held in preset
      if (fifoOutValid && lockLineN) begin
        next_state.txShift = fifoOutData;
        fifoPop = 1'b1;
      end else begin
        next_state.txShift = serdes_pkg::IDLE_WORD;
      end
    end else begin
      next_state.txShift = {1'b0, state.txShift[9:1]};
    end

    // loopback holds the line low and feeds the receiver
    next_state.serialOut = loopLine ? 1'b0 : state.txShift[0];
    rxBit = loopLine ? state.txShift[0] : serialLine;

    // retimed bit enters history, oldest bit lands in bit 0
    newHist = {rxBit, state.rxHist[9:1]};
    next_state.rxHist = newHist;
    wordDone = state.bitCount == serdes_pkg::BIT_LAST;
    // with alignment enabled, every bit time tests the latest ten bits
    commaSeen = alignLine && newHist == serdes_pkg::COMMA_WORD;

    // framing runs from data alone, no preset
    // free-running framing when no comma moves it
    next_state.bitCount = wordDone ? 4'h0 : state.bitCount + 4'h1;
    // Word after a misaligned comma is dropped while it waits
    if (wordDone && !state.pendingComma) begin
      next_state.holdWord = newHist;
    end
    if (commaSeen) begin
      next_state.holdWord = newHist;
      next_state.pendingComma = 1'b1;
      next_state.bitCount = 4'h0;
    end
    // preset framing follows the reference phase
    if (!lockLineN) begin
      next_state.bitCount = next_state.refPhase;
    end
    // pending comma forgotten once alignment is off
    if (!alignLine) begin
      next_state.pendingComma = 1'b0;
    end

    // realignment holds the counter, never skips ahead
    advance = 1'b1;
    slip = slipFor(state.byteCount);
    if (commaSeen) begin
      if (slip != 4'h0) begin
        advance = 1'b0;
        next_state.stall = slip - 4'h1;
      end else begin
        next_state.stall = 4'h0;
      end
    end else if (state.stall != 4'h0) begin
      advance = 1'b0;
      next_state.stall = state.stall - 4'h1;
    end

    if (advance) begin
      next_state.byteCount = (state.byteCount == serdes_pkg::BYTE_LAST) ?
                             5'h00 : state.byteCount + 5'h01;
      // word changes as either byte clock rises
      if (isRiseNext(state.byteCount)) begin
        next_state.rxWordOut = next_state.holdWord;
      end
      // comma word presented on the second clock's rise
      if (state.byteCount == serdes_pkg::BYTE_LAST &&
          next_state.pendingComma) begin
        next_state.commaDetect = 1'b1;
        next_state.pendingComma = 1'b0;
      end
      // pulse ends after half a reference period
      if (next_state.byteCount == serdes_pkg::PULSE_END) begin
        next_state.commaDetect = 1'b0;
      end
    end

    // antiphase byte clocks from one counter
    next_state.byteClockB = next_state.byteCount < serdes_pkg::BYTE_HALF;
    next_state.byteClockA = !next_state.byteClockB;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SERDES_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign txWordReady  = fifoInReady;
  assign serialOut    = state.serialOut;
  assign rxWordOut    = state.rxWordOut;
  assign rxByteClockA = state.byteClockA;
  assign rxByteClockB = state.byteClockB;
  assign commaDetect  = state.commaDetect;
endmodule : gigabit_serdes_comma_align

// file: verif/serdes_asserts.sv
// Checker of the byte clocks, comma pulse and loopback output
`timescale 1ns/1ps
module serdes_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [9:0] txWordIn,
  input wire logic       txWordValid,
  input wire logic       txWordReady,
  input wire logic       serialOut,
  input wire logic       serialIn,
  input wire logic       alignEnable,
  input wire logic       refLockN,
  input wire logic       loopbackEnable,
  input wire logic [9:0] rxWordOut,
  input wire logic       rxByteClockA,
  input wire logic       rxByteClockB,
  input wire logic       commaDetect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Saturating run of disabled cycles; a pulse may lag detection by 22
  logic [4:0] lowCount;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lowCount <= 5'h00;
    else if (alignEnable) lowCount <= 5'h00;
    else if (lowCount != 5'h1F) lowCount <= lowCount + 5'h01;
  end
  sequence pulseSeq;
    commaDetect[*5] ##1 !commaDetect;
  endsequence
  sequence highA;
    rxByteClockA[*8] ##1 rxByteClockA ##1 rxByteClockA;
  endsequence
  sequence highB;
    rxByteClockB[*8] ##1 rxByteClockB ##1 rxByteClockB;
  endsequence
  AST_ANTIPHASE: assert property (rxByteClockA != rxByteClockB)
    else $error("byte clocks not in antiphase");
  AST_B_NOT_SHORT: assert property ($rose(rxByteClockB) |-> highB)
    else $error("second byte clock high too short");
  AST_A_NOT_SHORT: assert property ($rose(rxByteClockA) |-> highA)
    else $error("first byte clock high too short");
  AST_PULSE_LEN: assert property ($rose(commaDetect) |-> pulseSeq)
    else $error("comma pulse length wrong");
  AST_PULSE_ON_B: assert property (
    $rose(commaDetect) |-> $rose(rxByteClockB))
    else $error("comma pulse not on second clock rise");
  AST_PULSE_WORD: assert property (
    commaDetect |-> rxWordOut == serdes_pkg::COMMA_WORD)
    else $error("comma pulse without comma word");
  AST_PULSE_EN: assert property (
    $rose(commaDetect) |-> lowCount < 5'h1E)
    else $error("comma pulse while alignment off");
  AST_WORD_ON_CLOCK: assert property (
    $changed(rxWordOut) |-> $rose(rxByteClockA) || $rose(rxByteClockB))
    else $error("received word changed off a clock rise");
  AST_LOOP_STATIC: assert property (
    loopbackEnable[*4] |-> serialOut == 1'b0)
    else $error("serial output moved in loopback");
endmodule : serdes_asserts
bind gigabit_serdes_comma_align serdes_asserts u_asserts (.clk(clk),
  .resetn(resetn), .txWordIn(txWordIn), .txWordValid(txWordValid),
  .txWordReady(txWordReady), .serialOut(serialOut), .serialIn(serialIn),
  .alignEnable(alignEnable), .refLockN(refLockN),
  .loopbackEnable(loopbackEnable), .rxWordOut(rxWordOut),
  .rxByteClockA(rxByteClockA), .rxByteClockB(rxByteClockB),
  .commaDetect(commaDetect));

// file: verif/remote_serial_tx.sv
// Remote transmitter sending one word repeatedly, bit 0 first
`timescale 1ns/1ps
module remote_serial_tx (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [9:0] word,
  output logic            serialLine
);
  logic [3:0] phase;
  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 4'h0;
      serialLine <= 1'b1;
    end else begin
      serialLine <= word[phase];
      phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
    end
  end
endmodule : remote_serial_tx

// file: verif/tb_gigabit_serdes_comma_align.sv
// Self-checking bench of the serializer, deserializer and aligner
`timescale 1ns/1ps
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  mismatches++; $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module tb_gigabit_serdes_comma_align;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [9:0] txWordIn = 10'h000;
  logic       txWordValid = 1'b0;
  logic       alignEnable = 1'b0;
  logic       refLockN = 1'b1;
  logic       loopbackEnable = 1'b0;
  logic [9:0] farWord = 10'h155;
  logic [9:0] got;
  logic       txWordReady, serialOut, serialIn, rxByteClockA, rxByteClockB;
  logic       commaDetect, seen;
  logic [9:0] rxWordOut;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         n;
  gigabit_serdes_comma_align dut (.clk(clk), .resetn(resetn),
    .txWordIn(txWordIn), .txWordValid(txWordValid), .txWordReady(txWordReady),
    .serialOut(serialOut), .serialIn(serialIn), .alignEnable(alignEnable),
    .refLockN(refLockN), .loopbackEnable(loopbackEnable),
    .rxWordOut(rxWordOut), .rxByteClockA(rxByteClockA),
    .rxByteClockB(rxByteClockB), .commaDetect(commaDetect));
  remote_serial_tx far (.clk(clk), .resetn(resetn), .word(farWord),
    .serialLine(serialIn));
  // reference derived inside from this clock
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      summarize();
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Held ten cycles so exactly one reference tick takes it
  task pushWord(input logic [9:0] w);
    @(negedge clk);
    txWordIn = w;
    txWordValid = 1'b1;
    repeat (10) @(negedge clk);
    txWordValid = 1'b0;
  endtask : pushWord
  initial begin
    repeat (12) @(negedge clk);
    `CHECK(rxByteClockB, 1'b1)
    `CHECK(rxByteClockA, 1'b0)
    `CHECK(commaDetect, 1'b0)
    resetn = 1'b1;
    pushWord(10'h2B5);
    for (n = 0; n < 40 && serialOut !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 10; n++) begin
      got[n] = serialOut;
      @(negedge clk);
    end
    `CHECK(got, 10'h2B5)
    $display("test transmit order done");
    farWord = serdes_pkg::COMMA_WORD;
    alignEnable = 1'b1;
    for (n = 0; n < 300 && commaDetect !== 1'b1; n++) @(negedge clk);
    `CHECK(rxWordOut, serdes_pkg::COMMA_WORD)
    `CHECK(rxByteClockB, 1'b1)
    for (n = 0; n < 20 && commaDetect === 1'b1; n++) @(negedge clk);
    `CHECK(n, 5)
    $display("test comma align done");
    alignEnable = 1'b0;
    repeat (30) @(negedge clk);
    seen = 1'b0;
    repeat (200) @(negedge clk) seen = seen | commaDetect;
    `CHECK(seen, 1'b0)
    $display("test align off done");
    loopbackEnable = 1'b1;
    repeat (4) @(negedge clk);
    seen = 1'b0;
    fork
      pushWord(10'h3FF);
      repeat (40) @(negedge clk) seen = seen | serialOut;
    join
    `CHECK(seen, 1'b0)
    loopbackEnable = 1'b0;
    $display("test loopback done");
    refLockN = 1'b0;
    repeat (4) @(negedge clk);
    for (n = 0; n < serdes_pkg::FIFO_DEPTH; n++) pushWord(10'h001 + n);
    `CHECK(txWordReady, 1'b0)
    refLockN = 1'b1;
    for (n = 0; n < 200 && txWordReady !== 1'b1; n++) @(negedge clk);
    `CHECK(txWordReady, 1'b1)
    $display("test fifo fill done");
    summarize();
  end
endmodule : tb_gigabit_serdes_comma_align
